// *** rtl/pmc_count_gate.sv ***
`include "pmc_defines.svh"

module pmc_count_gate (
    input  wire logic [31:0] i_mcf,
    input  wire logic        i_privilege_state_bit,
    input  wire logic        i_process_mark_bit,
    output logic             o_count_en
);

    logic user;
    logic mark;

    assign user = i_privilege_state_bit;
    assign mark = i_process_mark_bit;

    // each disable bit removes one half of one axis; combinations give
    // the nine monitored conditions, all clear gives free counting
    assign o_count_en = ~i_mcf[`PMC_MCF_INHIBIT]               // R5
                      & ~(i_mcf[`PMC_MCF_NO_SUP] & ~user)      // R2 R3
                      & ~(i_mcf[`PMC_MCF_NO_USER] & user)      // R2 R3
                      & ~(i_mcf[`PMC_MCF_NO_MARK] & mark)      // R2 R3
                      & ~(i_mcf[`PMC_MCF_NO_UNMARK] & ~mark);  // R4

endmodule

// *** rtl/pmc_defines.svh ***
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PMC_OFF_MCF        12'h000
`define PMC_OFF_MCS        12'h004
`define PMC_OFF_MST        12'h008
`define PMC_CNT_PAGE       8'h01
// ----------------------------------------------------------------
// first monitor control fields (little-endian bit index)
// ----------------------------------------------------------------
`define PMC_MCF_INHIBIT    31
`define PMC_MCF_NO_SUP     30
`define PMC_MCF_NO_USER    29
`define PMC_MCF_NO_MARK    28
`define PMC_MCF_NO_UNMARK  27
`define PMC_MCF_IRQ_EN     26
`define PMC_MCF_FREEZE     25
`define PMC_MCF_TBSEL_HI   24
`define PMC_MCF_TBSEL_LO   23
`define PMC_MCF_C1_IRQ_EN  15
`define PMC_MCF_CX_IRQ_EN  14
`define PMC_MCF_C1_SEL_HI  12
`define PMC_MCF_C1_SEL_LO  6
`define PMC_MCF_C2_SEL_HI  5
`define PMC_MCF_C2_SEL_LO  0
`define PMC_MCF_WMASK      32'hFF80_DFFF
// ----------------------------------------------------------------
// second monitor control fields
// ----------------------------------------------------------------
`define PMC_MCS_C3_SEL_HI  31
`define PMC_MCS_C3_SEL_LO  27
`define PMC_MCS_C4_SEL_HI  26
`define PMC_MCS_C4_SEL_LO  22
`define PMC_MCS_WMASK      32'hFFC0_0000
// ----------------------------------------------------------------
// machine state fields
// ----------------------------------------------------------------
`define PMC_MST_PRIV       14
`define PMC_MST_MARK       2
`define PMC_MST_WMASK      32'h0000_4004
// ----------------------------------------------------------------
// event codes and per-counter defined-code masks
// ----------------------------------------------------------------
`define PMC_EV_HOLD        7'h00
`define PMC_EV_CYCLE       7'h01
`define PMC_EV_COMPLETE    7'h02
`define PMC_EV_TBRISE      7'h03
`define PMC_EV_DISPATCH    7'h04
`define PMC_EV_THRESH      5'h0A
`define PMC_C1_VALID       32'h0000_1FFF
`define PMC_C2_VALID       32'h0001_FDFF
`define PMC_C3_VALID       32'h0003_BDFF
`define PMC_C4_VALID       32'h0000_7D7F
`define PMC_CNT_RESET      32'h0000_0000

`endif

// *** rtl/pmc_event_mux.sv ***
`include "pmc_defines.svh"

module pmc_event_mux (
    input  wire logic [6:0]          i_code,
    input  wire logic [31:0]         i_valid,
    input  wire logic [31:0]         i_aux,
    input  wire pmc_pkg::pmc_events_t i_ev,
    input  wire logic                i_tb_rise,
    output logic [1:0]               o_inc
);

    always_comb
    begin
        o_inc = 2'h0;
        unique case (i_code)
            `PMC_EV_HOLD:     o_inc = 2'h0;                       // R11
            `PMC_EV_CYCLE:    o_inc = 2'h1;                       // R12
            `PMC_EV_COMPLETE: o_inc = i_ev.completed;             // R14
            `PMC_EV_TBRISE:   o_inc = {1'b0, i_tb_rise};          // R13
            `PMC_EV_DISPATCH: o_inc = i_ev.dispatched;            // R14
            default:
            begin
                // codes past 31 or undefined for this counter hold
                if (i_code[6:5] == 2'h0 && i_valid[i_code[4:0]])
                begin
                    o_inc = {1'b0, i_aux[i_code[4:0]]};
                end
                else
                begin
                    o_inc = 2'h0;                                 // R20
                end
            end
        endcase
    end

endmodule

// *** rtl/pmc_pkg.sv ***
package pmc_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pmc_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } pmc_apb_rsp_t;

    typedef struct packed {
        logic [1:0]       completed;
        logic [1:0]       dispatched;
        logic [31:0]      timebase_low_word;
        logic             queue_pos0;
        logic [3:0][31:0] aux;
    } pmc_events_t;

    typedef struct packed {
        logic [31:0]      mcf;
        logic [31:0]      mcs;
        logic [31:0]      mst;
        logic [3:0][31:0] cnt;
        logic             tb_prev;
        logic             irq;
        logic [31:0]      prdata;
    } pmc_state_t;

endpackage

// *** rtl/pmc_top.sv ***
// Function
// R1 - machine state register carries a process mark bit at big-endian bit 29
// R2 - counting runs only while privilege and mark match programmed condition
// R3 - condition covers supervisor, user, marked and unmarked combinations
// R4 - with control bits 0 to 4 clear, counting is unconditional
// R5 - global inhibit bit set stops every counter regardless of state
// R6 - four independent 32-bit counters, overflow past 0x7FFFFFFF
// R7 - counter top bit set means overflowed and feeds the exception
// R8 - counter one event field is 7 bits at big-endian 19 to 25
// R9 - counter two event field is 6 bits at big-endian 26 to 31
// R10 - counters three and four have 5-bit event fields
// R11 - event code zero holds the counter value
// R12 - codes 1, 2, 4 count cycles, completions, dispatches
// R13 - code 3 counts rising edges of a selected time base bit
// R14 - multi-occurrence events add their per-cycle count
// R15 - threshold event on counter one watches queue position zero only
// R16 - threshold counts may be wrong for unaligned, multiple, string ops
// R17 - counter three and four fields sit in second control register
// R18 - interrupt needs global enable and matching counter enable
// R19 - freeze bit stops all counting once the interrupt is raised
// R20 - reserved codes hold; hard reset clears counters and controls
// R21 - software writes a counter directly, effective next cycle
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`include "pmc_defines.svh"

module pmc_top (
    input  wire logic                 i_sys_clk,
    input  wire logic                 i_reset_n,
    input  wire logic                 i_clk_en,
    input  wire pmc_pkg::pmc_apb_req_t i_apb,
    output pmc_pkg::pmc_apb_rsp_t     o_apb,
    input  wire pmc_pkg::pmc_events_t i_events,
    output logic                      o_perf_irq,
    output logic [3:0]                o_overflow
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    pmc_pkg::pmc_state_t s;
    pmc_pkg::pmc_state_t next_s;

    logic             setup;
    logic             access;
    logic             wr;
    logic             hit_mcf;
    logic             hit_mcs;
    logic             hit_mst;
    logic             hit_cnt;
    logic [1:0]       cnt_idx;
    logic             hit;
    logic [31:0]      rd_data;
    logic             count_en;
    logic             freeze;
    logic             tb_bit;
    logic             tb_rise;
    logic [3:0][6:0]  code;
    logic [3:0][31:0] valid;
    logic [3:0][31:0] aux;
    logic [3:0][1:0]  inc;
    logic             irq_cause;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    assign setup   = i_apb.psel & ~i_apb.penable;
    assign access  = i_apb.psel & i_apb.penable;
    assign wr      = access & i_apb.pwrite;
    assign hit_mcf = i_apb.paddr == `PMC_OFF_MCF;
    assign hit_mcs = i_apb.paddr == `PMC_OFF_MCS;
    assign hit_mst = i_apb.paddr == `PMC_OFF_MST;
    assign hit_cnt = i_apb.paddr[11:4] == `PMC_CNT_PAGE
                   && i_apb.paddr[1:0] == 2'h0;
    assign cnt_idx = i_apb.paddr[3:2];
    assign hit     = hit_mcf | hit_mcs | hit_mst | hit_cnt;

    // zero-wait slave; read data is captured in the setup cycle
    assign o_apb.pready  = 1'b1;
    assign o_apb.prdata  = s.prdata;
    assign o_apb.pslverr = access & ~hit;

    always_comb
    begin
        rd_data = 32'h0000_0000;
        if (hit_mcf)
        begin
            rd_data = s.mcf;
        end
        else if (hit_mcs)
        begin
            rd_data = s.mcs;
        end
        else if (hit_mst)
        begin
            rd_data = s.mst;
        end
        else if (hit_cnt)
        begin
            rd_data = s.cnt[cnt_idx];
        end
    end

    // ----------------------------------------------------------------
    // count gating
    // ----------------------------------------------------------------
    pmc_count_gate u_gate (
        .i_mcf                 (s.mcf),
        .i_privilege_state_bit (s.mst[`PMC_MST_PRIV]),
        .i_process_mark_bit    (s.mst[`PMC_MST_MARK]),                // R1
        .o_count_en            (count_en)
    );

    assign freeze = s.mcf[`PMC_MCF_FREEZE] & s.irq;                   // R19

    // ----------------------------------------------------------------
    // time base edge
    // ----------------------------------------------------------------
    always_comb
    begin
        unique case ({s.mcf[`PMC_MCF_TBSEL_HI], s.mcf[`PMC_MCF_TBSEL_LO]})
            2'b00: tb_bit = i_events.timebase_low_word[0];            // R13
            2'b01: tb_bit = i_events.timebase_low_word[8];
            2'b10: tb_bit = i_events.timebase_low_word[12];
            2'b11: tb_bit = i_events.timebase_low_word[16];
        endcase
    end

    // changing the select may give one spurious edge; cheap trade-off
    assign tb_rise = tb_bit & ~s.tb_prev;

    // ----------------------------------------------------------------
    // event selection per counter
    // ----------------------------------------------------------------
    assign code[0]  = s.mcf[`PMC_MCF_C1_SEL_HI:`PMC_MCF_C1_SEL_LO];   // R8
    assign code[1]  = {1'b0,
                       s.mcf[`PMC_MCF_C2_SEL_HI:`PMC_MCF_C2_SEL_LO]}; // R9
    assign code[2]  = {2'h0,
                       s.mcs[`PMC_MCS_C3_SEL_HI:`PMC_MCS_C3_SEL_LO]}; // R17
    assign code[3]  = {2'h0,
                       s.mcs[`PMC_MCS_C4_SEL_HI:`PMC_MCS_C4_SEL_LO]}; // R10
    assign valid[0] = `PMC_C1_VALID;
    assign valid[1] = `PMC_C2_VALID;
    assign valid[2] = `PMC_C3_VALID;
    assign valid[3] = `PMC_C4_VALID;

    // threshold source is gated here to queue position 0; unaligned, multiple
    // and string accesses are not corrected here
    always_comb
    begin
        aux = i_events.aux;
        aux[0][`PMC_EV_THRESH] = i_events.aux[0][`PMC_EV_THRESH]
                               & i_events.queue_pos0;                 // R15 R16
    end

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_mux
            pmc_event_mux u_mux (
                .i_code    (code[g]),
                .i_valid   (valid[g]),
                .i_aux     (aux[g]),
                .i_ev      (i_events),
                .i_tb_rise (tb_rise),
                .o_inc     (inc[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // overflow and interrupt
    // ----------------------------------------------------------------
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            o_overflow[i] = s.cnt[i][31];                             // R7
        end
    end

    assign irq_cause = s.mcf[`PMC_MCF_IRQ_EN]
                     & ((o_overflow[0] & s.mcf[`PMC_MCF_C1_IRQ_EN])
                     | (|o_overflow[3:1] & s.mcf[`PMC_MCF_CX_IRQ_EN])); // R18
    assign o_perf_irq = s.irq;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        if (setup)
        begin
            next_s.prdata = rd_data;
        end
        if (wr && hit_mcf)
        begin
            next_s.mcf = i_apb.pwdata & `PMC_MCF_WMASK;
        end
        if (wr && hit_mcs)
        begin
            next_s.mcs = i_apb.pwdata & `PMC_MCS_WMASK;
        end
        if (wr && hit_mst)
        begin
            next_s.mst = i_apb.pwdata & `PMC_MST_WMASK;               // R1
        end
        next_s.tb_prev = tb_bit;
        for (int i = 0; i < 4; i++)
        begin
            if (wr && hit_cnt && cnt_idx == 2'(i))
            begin
                next_s.cnt[i] = i_apb.pwdata;                         // R21
            end
            else if (count_en && !freeze)
            begin
                // counting continues past the top bit and may wrap
                next_s.cnt[i] = s.cnt[i] + {30'h0000_0000, inc[i]};   // R6
            end
        end
        next_s.irq = irq_cause;                                       // R7
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            s.mcf     <= 32'h0000_0000;                               // R20
            s.mcs     <= 32'h0000_0000;
            s.mst     <= 32'h0000_0000;
            s.cnt     <= {4{`PMC_CNT_RESET}};
            s.tb_prev <= 1'b0;
            s.irq     <= 1'b0;
            s.prdata  <= 32'h0000_0000;
        end
        else if (i_clk_en)
        begin
            s <= next_s;
        end
    end

endmodule

// *** tb/pmc_event_src.sv ***
module pmc_event_src (
    input  wire logic            i_sys_clk,
    input  wire logic            i_reset_n,
    input  wire logic [31:0]     i_tb_step,
    input  wire logic            i_pos0,
    input  wire logic [31:0]     i_aux,
    output pmc_pkg::pmc_events_t o_ev
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // time base free runs; two retire and one issues each cycle
    // ----
    logic [31:0] tb_word;
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            tb_word <= 32'h0000_0000;
        else
            tb_word <= tb_word + i_tb_step;
    end
    assign o_ev = '{completed: 2'h2, dispatched: 2'h1,
                    timebase_low_word: tb_word, queue_pos0: i_pos0,
                    aux: {4{i_aux}}};
endmodule

// *** tb/pmc_top_sva.sv ***
`include "pmc_defines.svh"

module pmc_top_sva (
    input wire logic                  i_sys_clk,
    input wire logic                  i_reset_n,
    input wire logic                  i_clk_en,
    input wire pmc_pkg::pmc_apb_req_t i_apb,
    input wire pmc_pkg::pmc_apb_rsp_t o_apb,
    input wire pmc_pkg::pmc_events_t  i_events,
    input wire logic                  o_perf_irq,
    input wire logic [3:0]            o_overflow
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // control shadows: counters are unseen, so gate on the controls
    // ----
    logic [31:0] mcf;
    logic [31:0] mst;
    logic        wr;
    logic        cw;
    logic        why;
    assign wr  = i_apb.psel & i_apb.penable & i_apb.pwrite & i_clk_en;
    assign cw  = wr & (i_apb.paddr[11:4] == `PMC_CNT_PAGE)
               & (i_apb.paddr[1:0] == 2'h0);
    assign why = mcf[`PMC_MCF_IRQ_EN]
               & ((o_overflow[0] & mcf[`PMC_MCF_C1_IRQ_EN])
               | ((|o_overflow[3:1]) & mcf[`PMC_MCF_CX_IRQ_EN]));
    always_ff @(posedge i_sys_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            mcf <= 32'h0000_0000;
            mst <= 32'h0000_0000;
        end
        else if (wr && i_apb.paddr == `PMC_OFF_MCF)
            mcf <= i_apb.pwdata & `PMC_MCF_WMASK;
        else if (wr && i_apb.paddr == `PMC_OFF_MST)
            mst <= i_apb.pwdata & `PMC_MST_WMASK;
    end
    default clocking dc @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    AST_RESET_QUIET: assert property (
        $rose(i_reset_n) |-> (o_overflow == 4'h0) && !o_perf_irq)
        else $error("outputs not clear after reset");
    AST_IRQ_RAISE: assert property (
        i_clk_en && why |=> o_perf_irq)
        else $error("interrupt missing");
    AST_IRQ_CAUSE: assert property (
        o_perf_irq |-> $past(why))
        else $error("interrupt without enabled overflow");
    AST_INHIBIT: assert property (
        mcf[`PMC_MCF_INHIBIT] && !cw |=> $stable(o_overflow))
        else $error("counting while inhibited");
    AST_FREEZE: assert property (
        mcf[`PMC_MCF_FREEZE] && o_perf_irq && !cw |=> $stable(o_overflow))
        else $error("counting after freeze");
    AST_USER_GATE: assert property (
        mcf[`PMC_MCF_NO_USER] && mst[`PMC_MST_PRIV] && !cw
        |=> $stable(o_overflow))
        else $error("counting in disabled user state");
    AST_MARK_GATE: assert property (
        mcf[`PMC_MCF_NO_MARK] && mst[`PMC_MST_MARK] && !cw
        |=> $stable(o_overflow))
        else $error("counting in disabled marked state");
    AST_CNT_WRITE: assert property (
        cw |=> o_overflow[$past(i_apb.paddr[3:2])]
               == $past(i_apb.pwdata[31]))
        else $error("written counter top bit not shown");
    cover property ($rose(o_perf_irq));
    cover property ($rose(o_overflow[0]));
    cover property (o_apb.pslverr);
endmodule

bind pmc_top pmc_top_sva u_sva (
    .i_sys_clk  (i_sys_clk),
    .i_reset_n  (i_reset_n),
    .i_clk_en   (i_clk_en),
    .i_apb      (i_apb),
    .o_apb      (o_apb),
    .i_events   (i_events),
    .o_perf_irq (o_perf_irq),
    .o_overflow (o_overflow)
);

// *** tb/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  i_sys_clk;
    logic                  i_reset_n;
    logic                  clk_en;
    logic [31:0]           step;
    logic [31:0]           aux;
    logic                  pos0;
    logic [31:0]           rd;
    logic                  slv;
    logic [31:0]           c1;
    logic                  irq;
    logic [3:0]            ovf;
    int                    error_cnt;
    int                    cmp_count;
    pmc_pkg::pmc_apb_req_t apb_req;
    pmc_pkg::pmc_apb_rsp_t apb_rsp;
    pmc_pkg::pmc_events_t  ev;
    // enabled privilege/mark states per condition, with its disable bits
    logic [7:0]            g [9] = '{8'h0F, 8'h43, 8'h8C, 8'h98, 8'hA4,
                                     8'h52, 8'h61, 8'h1A, 8'h25};
    pmc_top uut (
        .i_sys_clk  (i_sys_clk),
        .i_reset_n  (i_reset_n),
        .i_clk_en   (clk_en),
        .i_apb      (apb_req),
        .o_apb      (apb_rsp),
        .i_events   (ev),
        .o_perf_irq (irq),
        .o_overflow (ovf)
    );
    pmc_event_src src (
        .i_sys_clk (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_tb_step (step),
        .i_pos0    (pos0),
        .i_aux     (aux),
        .o_ev      (ev)
    );
    // ----
    // helpers
    // ----
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge i_sys_clk);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge i_sys_clk);
        apb_req.penable <= 1'b1;
        // only the watchdog ends a wait for the answer
        do
        begin
            @(posedge i_sys_clk);
        end
        while (apb_rsp.pready !== 1'b1);
        rd = apb_rsp.prdata;
        slv = apb_rsp.pslverr;
        apb_req <= '0;
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask
    // counts for exactly 16 cycles, then inhibits again
    task automatic run(input logic [31:0] cfg);
        apb(1'b1, 12'h000, cfg);
        repeat (13) @(posedge i_sys_clk);
        apb(1'b1, 12'h000, cfg | 32'h8000_0000);
    endtask
    initial
    begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    initial
    begin
        repeat (20000) @(posedge i_sys_clk);
        error_cnt++;
        tally_and_finish();
    end
    // ----
    // tests
    // ----
    initial
    begin
        i_reset_n = 1'b0;
        clk_en = 1'b1;
        apb_req = '0;
        step = 32'h0000_0001;
        aux = 32'h0000_0000;
        pos0 = 1'b0;
        error_cnt = 0;
        cmp_count = 0;
        repeat (2) @(posedge i_sys_clk);
        i_reset_n <= 1'b1;
        for (int i = 0; i < 7; i++)
            rchk(12'(i < 3 ? 4 * i : 4 * i + 4), 32'h0000_0000);
        apb(1'b1, 12'h008, 32'hFFFF_FFFF);
        rchk(12'h008, 32'h0000_4004);
        apb(1'b1, 12'h004, 32'hFFFF_FFFF);
        rchk(12'h004, 32'hFFC0_0000);
        rchk(12'h00C, 32'h0000_0000);
        check({31'h0, slv}, 32'h0000_0001);
        // inhibit first: all-clear control would count freely
        apb(1'b1, 12'h000, 32'h8000_0000);
        apb(1'b1, 12'h004, 32'h20C0_0000);
        for (int s = 0; s < 4; s++)
        begin
            step <= 32'h0000_0001 << (s == 0 ? 0 : 4 * s + 4);
            // select the time base bit ahead, so no edge is invented
            apb(1'b1, 12'h000, 32'h8000_0000 | (32'(s) << 23));
            run(32'h0000_0042 | (32'(s) << 23));
            for (int k = 0; k < 4; k++)
                rchk(12'(16 + 4 * k), 32'((s + 1)
                     * (k == 1 ? 32 : k == 3 ? 8 : 16)));
        end
        apb(1'b1, 12'h010, 32'h0000_0000);
        c1 = 32'h0000_0000;
        for (int i = 0; i < 9; i++)
            for (int st = 0; st < 4; st++)
            begin
                apb(1'b1, 12'h008, {17'h0, st[1], 11'h0, st[0], 2'h0});
                run({1'b0, g[i][7:4], 27'h0} | 32'h0000_0040);
                if (g[i][st])
                    c1 = c1 + 32'h0000_0010;
                rchk(12'h010, c1);
            end
        aux <= 32'hFFFF_FFFF;
        for (int k = 0; k < 4; k++)
            apb(1'b1, 12'(16 + 4 * k), 32'h0000_0000);
        apb(1'b1, 12'h004, 32'h49C0_0000);
        run(32'h0000_0289);
        pos0 <= 1'b1;
        run(32'h0000_0285);
        for (int k = 0; k < 4; k++)
            rchk(12'(16 + 4 * k), k < 2 ? 32'h10 : 32'h0);
        // a write while the clock enable is low must not land
        clk_en <= 1'b0;
        apb(1'b1, 12'h010, 32'h0000_0055);
        clk_en <= 1'b1;
        rchk(12'h010, 32'h0000_0010);
        apb(1'b1, 12'h010, 32'h7FFF_FFFE);
        apb(1'b1, 12'h000, 32'h0000_8040);
        repeat (8) @(posedge i_sys_clk);
        #1;
        check({27'h0, irq, ovf}, 32'h0000_0001);
        apb(1'b1, 12'h000, 32'h0600_8040);
        repeat (3) @(posedge i_sys_clk);
        #1;
        check({31'h0, irq}, 32'h0000_0001);
        apb(1'b0, 12'h010, 32'h0000_0000);
        c1 = rd;
        rchk(12'h010, c1);
        check({31'h0, c1[31]}, 32'h0000_0001);
        apb(1'b1, 12'h000, 32'h8400_4000);
        repeat (2) @(posedge i_sys_clk);
        #1;
        check({31'h0, irq}, 32'h0000_0000);
        apb(1'b1, 12'h01C, 32'h8000_0000);
        repeat (2) @(posedge i_sys_clk);
        #1;
        check({27'h0, irq, ovf}, 32'h0000_0019);
        tally_and_finish();
    end
endmodule
